// ===== verilog/sbr_top.sv
// Purpose: data holding pair and rate generator of an asynchronous serial port
// Assumes: single bus clock REF_CLK_IN, byte register port with one-cycle read data
// Notes:   includes a minimal line shifter so the holding registers have a source and sink
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
// Notes on behaviour
// - data address: write tx, read rx
// - tx holding loads output shift register
// - rx holding loaded from input shifter
// - first stage factor 1,3,4,13
// - tx divisor two to field power
// - rx divisor two to field power
// - tx rate is clock over product
// - rx rate is clock over product
// - nonzero tx fine replaces tx divisor
// - nonzero rx fine replaces rx divisor
// - rx fine divides before sixteen stage
// - tx fine divides before sixteen stage
// - fine dividers reset to zero
// - rate prescaler bits reset to zero
// - empty flag cleared by status-read then write
// - word length selects eight or nine bits
module sbr_top (
    input  wire logic       REF_CLK_IN,
    input  wire logic       RESET_N_IN,
    input  wire logic [7:0] ADDR_IN,
    input  wire logic [7:0] WDATA_IN,
    input  wire logic       WR_IN,
    input  wire logic       RD_IN,
    output logic      [7:0] RDATA_OUT,
    input  wire logic       RXD_IN,
    output logic            TXD_OUT,
    output logic            IRQ_OUT
);
    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    // first stage factor minus one
    function automatic logic [3:0] first_stage_m1(input logic [1:0] code);
        logic [3:0] f;
        f = 4'h0;
        case (code)
            2'b00: f = 4'h0;
            2'b01: f = 4'h2;
            2'b10: f = 4'h3;
            default: f = 4'hC;
        endcase
        return f;
    endfunction : first_stage_m1

    // rate tick period minus one: first stage times divisor, fine overrides divisor
    function automatic logic [11:0] rate_m1(input logic [1:0] pcode, input logic [2:0] dcode,
                                            input logic [7:0] fine);
        logic [11:0] pf;
        logic [11:0] df;
        pf = {8'h00, first_stage_m1(pcode)} + 12'h001;
        df = (fine != 8'h00) ? {4'h0, fine} : (12'h001 << dcode);
        return 12'(pf * df - 12'h001);
    endfunction : rate_m1

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [7:0]  rate_config_r;
    logic [7:0]  rx_fine_factor_r;
    logic [7:0]  tx_fine_factor_r;
    logic [7:0]  ctrl_a_r;
    logic [7:0]  ctrl_b_r;
    logic [7:0]  irq_mask_r;
    logic [7:0]  tx_holding_reg_r;
    logic [7:0]  rx_holding_reg_r;
    logic        rx_bit8_r;
    logic        tx_empty_flag_r;
    logic        tx_done_r;
    logic        rx_full_r;
    logic        overrun_r;
    logic        framing_r;
    logic        status_seen_r;
    logic [7:0]  rdata_r;
    logic [11:0] tx_pre_r;
    logic [11:0] rx_pre_r;
    logic        tx_tick;
    logic        rx_tick;
    logic [2:0]  rxd_sync_r;
    logic        rxd_level_r;
    logic        txd_r;

    typedef enum logic [1:0] {
        SBR_IDLE  = 2'b00,
        SBR_SHIFT = 2'b01,
        SBR_STOP  = 2'b10
    } sbr_state_e;

    sbr_state_e  tx_state_r;
    sbr_state_e  rx_state_r;
    logic [3:0]  tx_tick_r;
    logic [3:0]  tx_bit_r;
    logic [9:0]  tx_shift_r;
    logic [3:0]  rx_tick_r;
    logic [3:0]  rx_bit_r;
    logic [8:0]  rx_shift_r;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    wire         sel_status = (ADDR_IN == sbr_pkg::LINE_STATUS_OFS);
    wire         sel_data   = (ADDR_IN == sbr_pkg::CHAR_HOLDING_OFS);
    wire         sel_rate   = (ADDR_IN == sbr_pkg::RATE_CONFIG_OFS);
    wire         sel_ca     = (ADDR_IN == sbr_pkg::FRAME_CONTROL_A_OFS);
    wire         sel_cb     = (ADDR_IN == sbr_pkg::FRAME_CONTROL_B_OFS);
    wire         sel_rxf    = (ADDR_IN == sbr_pkg::RX_FINE_DIVIDER_OFS);
    wire         sel_txf    = (ADDR_IN == sbr_pkg::TX_FINE_DIVIDER_OFS);
    wire         sel_mask   = (ADDR_IN == sbr_pkg::IRQ_MASK_OFS);
    wire         data_wr    = WR_IN && sel_data;
    wire         data_rd    = RD_IN && sel_data;
    wire         nine_bits  = ctrl_a_r[sbr_pkg::CA_WORD_LEN];
    wire         tx_en      = ctrl_b_r[sbr_pkg::CB_TX_ENABLE];
    wire         rx_en      = ctrl_b_r[sbr_pkg::CB_RX_ENABLE];
    wire  [3:0]  frame_last = nine_bits ? sbr_pkg::BITS_9_FRAME : sbr_pkg::BITS_8_FRAME;

    // status byte as software sees it
    wire  [7:0]  status_byte = {tx_empty_flag_r, tx_done_r, rx_full_r, 1'b0, overrun_r, 1'b0, framing_r, 1'b0};

    // read mux, unmapped addresses read zero
    logic [7:0]  rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        if (sel_status) begin
            rd_mux = status_byte;
        end else if (sel_data) begin
            rd_mux = rx_holding_reg_r;
        end else if (sel_rate) begin
            rd_mux = rate_config_r;
        end else if (sel_ca) begin
            rd_mux = {rx_bit8_r, ctrl_a_r[6:0]};
        end else if (sel_cb) begin
            rd_mux = ctrl_b_r;
        end else if (sel_rxf) begin
            rd_mux = rx_fine_factor_r;
        end else if (sel_txf) begin
            rd_mux = tx_fine_factor_r;
        end else if (sel_mask) begin
            rd_mux = irq_mask_r;
        end
    end

    // ------------------------------------------------------------
    // rate generators
    // ------------------------------------------------------------
    wire  [11:0] tx_period_m1 = rate_m1(rate_config_r[sbr_pkg::FIRST_STAGE_HI:sbr_pkg::FIRST_STAGE_LO],
                                        rate_config_r[sbr_pkg::TX_DIV_HI:sbr_pkg::TX_DIV_LO],
                                        tx_fine_factor_r);
    wire  [11:0] rx_period_m1 = rate_m1(rate_config_r[sbr_pkg::FIRST_STAGE_HI:sbr_pkg::FIRST_STAGE_LO],
                                        rate_config_r[sbr_pkg::RX_DIV_HI:sbr_pkg::RX_DIV_LO],
                                        rx_fine_factor_r);
    assign tx_tick = (tx_pre_r == 12'h000);
    assign rx_tick = (rx_pre_r == 12'h000);

    // down counters that pulse one rate tick per period
    always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            tx_pre_r <= 12'h000;
            rx_pre_r <= 12'h000;
        end else begin
            tx_pre_r <= tx_tick ? tx_period_m1 : tx_pre_r - 12'h001;
            rx_pre_r <= rx_tick ? rx_period_m1 : rx_pre_r - 12'h001;
        end
    end

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            rate_config_r    <= sbr_pkg::RATE_CONFIG_RST;
            rx_fine_factor_r <= sbr_pkg::FINE_DIVIDER_RST;
            tx_fine_factor_r <= sbr_pkg::FINE_DIVIDER_RST;
            ctrl_a_r         <= sbr_pkg::CONTROL_RST;
            ctrl_b_r         <= sbr_pkg::CONTROL_RST;
            irq_mask_r       <= sbr_pkg::IRQ_MASK_RST;
            tx_holding_reg_r <= 8'h00;
        end else begin
            if (WR_IN && sel_rate) begin
                rate_config_r <= WDATA_IN;
            end
            if (WR_IN && sel_rxf) begin
                rx_fine_factor_r <= WDATA_IN;
            end
            if (WR_IN && sel_txf) begin
                tx_fine_factor_r <= WDATA_IN;
            end
            if (WR_IN && sel_ca) begin
                ctrl_a_r <= {1'b0, WDATA_IN[6:0]};
            end
            if (WR_IN && sel_cb) begin
                ctrl_b_r <= WDATA_IN;
            end
            if (WR_IN && sel_mask) begin
                irq_mask_r <= WDATA_IN;
            end
            if (data_wr) begin
                tx_holding_reg_r <= WDATA_IN;
            end
        end
    end

    // read data one cycle after the strobe
    always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= RD_IN ? rd_mux : 8'h00;
        end
    end

    // ------------------------------------------------------------
    // status flags: set wins over clear
    // ------------------------------------------------------------
    wire         tx_load     = tx_en && !tx_empty_flag_r && (tx_state_r == SBR_IDLE) && tx_tick;
    wire         frame_sent  = (tx_state_r == SBR_STOP) && tx_tick && (tx_tick_r == sbr_pkg::TICKS_PER_BIT_M1);
    wire         rx_deliver  = (rx_state_r == SBR_STOP) && rx_tick && (rx_tick_r == sbr_pkg::MID_BIT_TICK);
    wire         clr_tx      = status_seen_r && data_wr;
    wire         clr_rx      = status_seen_r && data_rd;

    always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            tx_empty_flag_r <= 1'b1;
            tx_done_r       <= 1'b1;
            rx_full_r       <= 1'b0;
            overrun_r       <= 1'b0;
            framing_r       <= 1'b0;
            status_seen_r   <= 1'b0;
        end else begin
            if (RD_IN && sel_status) begin
                status_seen_r <= 1'b1;
            end else if (clr_tx || clr_rx) begin
                status_seen_r <= 1'b0;
            end
            tx_empty_flag_r <= tx_load | (tx_empty_flag_r & ~clr_tx);
            tx_done_r       <= frame_sent | (tx_done_r & ~clr_tx);
            rx_full_r       <= (rx_deliver & ~rx_full_r) | (rx_full_r & ~clr_rx);
            overrun_r       <= (rx_deliver & rx_full_r) | (overrun_r & ~clr_rx);
            framing_r       <= (rx_deliver & ~rx_full_r & ~rxd_level_r) | (framing_r & ~clr_rx);
        end
    end

    // ------------------------------------------------------------
    // transmit shifter
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            tx_state_r <= SBR_IDLE;
            tx_tick_r  <= 4'h0;
            tx_bit_r   <= 4'h0;
            tx_shift_r <= 10'h3FF;
            txd_r      <= 1'b1;
        end else begin
            case (tx_state_r)
                SBR_IDLE: begin
                    txd_r <= 1'b1;
                    if (tx_load) begin
                        tx_shift_r <= {ctrl_a_r[sbr_pkg::CA_TX_BIT8], tx_holding_reg_r, 1'b0};
                        tx_tick_r  <= 4'h0;
                        tx_bit_r   <= 4'h0;
                        tx_state_r <= SBR_SHIFT;
                    end
                end
                SBR_SHIFT: begin
                    txd_r <= tx_shift_r[0];
                    if (tx_tick) begin
                        tx_tick_r <= tx_tick_r + 4'h1;
                        if (tx_tick_r == sbr_pkg::TICKS_PER_BIT_M1) begin
                            tx_shift_r <= {1'b1, tx_shift_r[9:1]};
                            tx_bit_r   <= tx_bit_r + 4'h1;
                            if (tx_bit_r == frame_last - 4'h1) begin
                                tx_state_r <= SBR_STOP;
                            end
                        end
                    end
                end
                default: begin
                    txd_r <= 1'b1;                                    // stop bit
                    if (tx_tick) begin
                        tx_tick_r <= tx_tick_r + 4'h1;
                        if (tx_tick_r == sbr_pkg::TICKS_PER_BIT_M1) begin
                            tx_state_r <= SBR_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // receive synchroniser and shifter
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            rxd_sync_r  <= 3'b111;
            rxd_level_r <= 1'b1;
        end else begin
            rxd_sync_r <= {rxd_sync_r[1:0], RXD_IN};
            if (rxd_sync_r[1] == rxd_sync_r[2]) begin
                rxd_level_r <= rxd_sync_r[2];
            end
        end
    end

    always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            rx_state_r       <= SBR_IDLE;
            rx_tick_r        <= 4'h0;
            rx_bit_r         <= 4'h0;
            rx_shift_r       <= 9'h000;
            rx_holding_reg_r <= 8'h00;
            rx_bit8_r        <= 1'b0;
        end else begin
            case (rx_state_r)
                SBR_IDLE: begin
                    if (rx_en && !rxd_level_r && rx_tick) begin
                        rx_tick_r  <= 4'h1;
                        rx_bit_r   <= 4'h0;
                        rx_state_r <= SBR_SHIFT;
                    end
                end
                SBR_SHIFT: begin
                    if (rx_tick) begin
                        rx_tick_r <= rx_tick_r + 4'h1;
                        if (rx_tick_r == sbr_pkg::MID_BIT_TICK) begin
                            if (rx_bit_r == 4'h0 && rxd_level_r) begin
                                rx_state_r <= SBR_IDLE;               // false start
                            end else begin
                                if (rx_bit_r != 4'h0) begin
                                    rx_shift_r <= nine_bits ? {rxd_level_r, rx_shift_r[8:1]}
                                                            : {1'b0, rxd_level_r, rx_shift_r[7:1]};
                                end
                                rx_bit_r <= rx_bit_r + 4'h1;
                                if (rx_bit_r == frame_last - 4'h1) begin
                                    rx_state_r <= SBR_STOP;
                                end
                            end
                        end
                    end
                end
                default: begin
                    if (rx_tick) begin
                        rx_tick_r <= rx_tick_r + 4'h1;
                        if (rx_tick_r == sbr_pkg::MID_BIT_TICK) begin
                            rx_state_r <= SBR_IDLE;
                            if (!rx_full_r) begin
                                rx_holding_reg_r <= nine_bits ? rx_shift_r[7:0] : rx_shift_r[7:0];
                                rx_bit8_r        <= rx_shift_r[8];
                            end
                        end
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign RDATA_OUT = rdata_r;
    assign TXD_OUT   = txd_r;
    assign IRQ_OUT   = |(status_byte & irq_mask_r);

endmodule : sbr_top

// ===== verilog/sbr_pkg.sv
// Purpose: shared constants of the serial rate and data register block
// Assumes: 8-bit register port, byte offsets as mapped on the internal bus
// Notes:   one clock, asynchronous active-low reset
package sbr_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] LINE_STATUS_OFS     = 8'h50;
    localparam logic [7:0] CHAR_HOLDING_OFS    = 8'h51;
    localparam logic [7:0] RATE_CONFIG_OFS     = 8'h52;
    localparam logic [7:0] FRAME_CONTROL_A_OFS = 8'h53;
    localparam logic [7:0] FRAME_CONTROL_B_OFS = 8'h54;
    localparam logic [7:0] RX_FINE_DIVIDER_OFS = 8'h55;
    localparam logic [7:0] TX_FINE_DIVIDER_OFS = 8'h57;
    localparam logic [7:0] IRQ_MASK_OFS        = 8'h58;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int FIRST_STAGE_HI = 7;
    localparam int FIRST_STAGE_LO = 6;
    localparam int TX_DIV_HI      = 5;
    localparam int TX_DIV_LO      = 3;
    localparam int RX_DIV_HI      = 2;
    localparam int RX_DIV_LO      = 0;
    localparam int ST_TX_EMPTY    = 7;
    localparam int ST_TX_DONE     = 6;
    localparam int ST_RX_FULL     = 5;
    localparam int ST_IDLE        = 4;
    localparam int ST_OVERRUN     = 3;
    localparam int ST_NOISE       = 2;
    localparam int ST_FRAMING     = 1;
    localparam int CA_RX_BIT8     = 7;
    localparam int CA_TX_BIT8     = 6;
    localparam int CA_WORD_LEN    = 4;
    localparam int CB_TX_ENABLE   = 3;
    localparam int CB_RX_ENABLE   = 2;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] LINE_STATUS_RST  = 8'hC0;
    localparam logic [7:0] RATE_CONFIG_RST  = 8'h00;
    localparam logic [7:0] FINE_DIVIDER_RST = 8'h00;
    localparam logic [7:0] CONTROL_RST      = 8'h00;
    localparam logic [7:0] IRQ_MASK_RST     = 8'h00;
    // ------------------------------------------------------------
    // timing counts
    // ------------------------------------------------------------
    localparam logic [3:0] TICKS_PER_BIT_M1 = 4'hF;  // sixteen rate ticks a bit
    localparam logic [3:0] MID_BIT_TICK     = 4'h7;  // sample point in the bit
    localparam logic [3:0] BITS_8_FRAME     = 4'h9;  // start plus eight data
    localparam logic [3:0] BITS_9_FRAME     = 4'hA;  // start plus nine data
endpackage : sbr_pkg

// ===== bench/sbr_top_properties.sv
// Purpose: port assertions for the serial rate and data register block
// Assumes: mirrors of writable registers reset as the design does
// Notes:   bound to sbr_top at the foot of this file
`timescale 1ns/1ps
module sbr_top_chk (
    input wire logic       REF_CLK_IN,
    input wire logic       RESET_N_IN,
    input wire logic [7:0] ADDR_IN,
    input wire logic [7:0] WDATA_IN,
    input wire logic       WR_IN,
    input wire logic       RD_IN,
    input wire logic [7:0] RDATA_OUT,
    input wire logic       RXD_IN,
    input wire logic       TXD_OUT,
    input wire logic       IRQ_OUT
);
    logic [7:0] rate_r;
    logic [7:0] rxf_r;
    logic [7:0] txf_r;
    logic [7:0] mask_r;
    logic [7:0] ctla_r;
    // ----------------------------------------
    // register mirrors
    // ----------------------------------------
    always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            rate_r <= 8'h00;
            rxf_r  <= 8'h00;
            txf_r  <= 8'h00;
            mask_r <= 8'h00;
            ctla_r <= 8'h00;
        end else if (WR_IN) begin
            if (ADDR_IN == 8'h52) rate_r <= WDATA_IN;
            if (ADDR_IN == 8'h55) rxf_r <= WDATA_IN;
            if (ADDR_IN == 8'h57) txf_r <= WDATA_IN;
            if (ADDR_IN == 8'h58) mask_r <= WDATA_IN;
            if (ADDR_IN == 8'h53) ctla_r <= WDATA_IN;
        end
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (!RESET_N_IN);
    chk_rdata_quiet: assert property (!RD_IN |=> RDATA_OUT == 8'h00)
        else $error("read data not idle");
    chk_unmapped_read: assert property (RD_IN && ADDR_IN == 8'h56 |=> RDATA_OUT == 8'h00)
        else $error("unmapped read not zero");
    chk_rate_read: assert property (RD_IN && ADDR_IN == 8'h52 |=> RDATA_OUT == rate_r)
        else $error("rate register readback");
    chk_rx_fine_read: assert property (RD_IN && ADDR_IN == 8'h55 |=> RDATA_OUT == rxf_r)
        else $error("rx fine readback");
    chk_tx_fine_read: assert property (RD_IN && ADDR_IN == 8'h57 |=> RDATA_OUT == txf_r)
        else $error("tx fine readback");
    chk_status_spare: assert property (RD_IN && ADDR_IN == 8'h50 |=> !RDATA_OUT[0])
        else $error("status spare bit set");
    chk_word_len: assert property (RD_IN && ADDR_IN == 8'h53 |=> RDATA_OUT[6:4] == ctla_r[6:4])
        else $error("word length readback");
    chk_start_bit: assert property ($fell(TXD_OUT) |-> !TXD_OUT [*8])
        else $error("start bit too short");
    chk_irq_masked: assert property (mask_r == 8'h00 |-> !IRQ_OUT)
        else $error("interrupt while fully masked");
endmodule : sbr_top_chk
bind sbr_top sbr_top_chk u_chk (.REF_CLK_IN(REF_CLK_IN), .RESET_N_IN(RESET_N_IN), .ADDR_IN(ADDR_IN),
    .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT), .RXD_IN(RXD_IN),
    .TXD_OUT(TXD_OUT), .IRQ_OUT(IRQ_OUT));

// ===== bench/sbr_line_partner.sv
// Purpose: remote asynchronous transceiver on the serial line
// Assumes: bit period given in bus clocks by the caller
// Notes:   line rests high between frames
`timescale 1ns/1ps
module sbr_line_partner (
    input  wire logic REF_CLK_IN,
    input  wire logic TXD_IN,
    output logic      RXD_OUT
);
    initial RXD_OUT = 1'b1;
    // send start, LSB first data, stop
    task automatic send(input logic [8:0] d, input int nb, input int per);
        for (int i = 0; i <= nb + 1; i++) begin
            @(posedge REF_CLK_IN);
            RXD_OUT <= (i == 0) ? 1'b0 : (i > nb) ? 1'b1 : d[i - 1];
            repeat (per - 1) @(posedge REF_CLK_IN);
        end
    endtask : send
    // sample data and stop bits at mid-bit
    task automatic recv(input int nb, input int per, output logic [9:0] w);
        int n;
        w = 10'h000;
        n = 0;
        while (TXD_IN !== 1'b0 && n < 40000) begin
            @(posedge REF_CLK_IN);
            n++;
        end
        repeat (per / 2) @(posedge REF_CLK_IN);
        for (int i = 0; i <= nb; i++) begin
            repeat (per) @(posedge REF_CLK_IN);
            w[i] = TXD_IN;
        end
    endtask : recv
endmodule : sbr_line_partner

// ===== bench/sbr_top_tb.sv
// Purpose: self-checking bench for the serial rate and data register block
// Assumes: bit period = 16 * first factor * divisor clocks
// Notes:   frames cross both ways at once
`timescale 1ns/1ps
module sbr_top_tb;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic [7:0] rdata;
    logic       rxd;
    logic       txd;
    logic       irq;
    int         miscompares = 0;
    int         checked = 0;
    int         fs[4] = '{1, 3, 4, 13};
    logic [7:0] cfg[7][3] = '{'{8'h00, 8'h00, 8'h00}, '{8'h4B, 8'h00, 8'h00}, '{8'h90, 8'h00, 8'h07},
        '{8'hC1, 8'h00, 8'h00}, '{8'h38, 8'h00, 8'h00}, '{8'h40, 8'h05, 8'h00}, '{8'h06, 8'h00, 8'h80}};
    bit         nine[7] = '{0, 0, 0, 1, 0, 1, 0};
    logic [7:0] ra[6] = '{8'h50, 8'h52, 8'h55, 8'h57, 8'h56, 8'h58};
    logic [7:0] re[6] = '{8'hC0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    sbr_top dut (.REF_CLK_IN(clk), .RESET_N_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
        .RD_IN(rd), .RDATA_OUT(rdata), .RXD_IN(rxd), .TXD_OUT(txd), .IRQ_OUT(irq));
    sbr_line_partner far (.REF_CLK_IN(clk), .TXD_IN(txd), .RXD_OUT(rxd));
    // bus clock
    initial forever #5 clk = ~clk;
    task automatic check(input logic [9:0] seen, input logic [9:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;  // let the write settle before anything looks at outputs
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_reg
    // bit period in clocks, lo picks the divisor field
    function automatic int per(input logic [7:0] r, input logic [7:0] f, input int lo);
        int dv;
        dv = r[lo +: 3];
        return 16 * fs[r[7:6]] * ((f != 8'h00) ? int'(f) : (1 << dv));
    endfunction : per
    task automatic conclude();
        $display("compares %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : conclude
    // watchdog, 90k clocks, well above the slowest expected run of about 60k clocks
    initial begin
        #900000;
        miscompares++;
        conclude();
    end
    // main sequence
    initial begin
        logic [7:0] v;
        logic [7:0] tb;
        logic [8:0] rb;
        logic [9:0] got;
        int         nb;
        void'($urandom(32'hBEC2));
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        wr_reg(8'h50, 8'h00);
        foreach (ra[k]) begin
            rd_reg(ra[k], v);
            check(10'(v), 10'(re[k]));
        end
        for (int i = 0; i < 7; i++) begin
            tb = 8'($urandom);
            rb = 9'($urandom);
            nb = nine[i] ? 9 : 8;
            wr_reg(8'h52, cfg[i][0]);
            wr_reg(8'h57, cfg[i][1]);
            wr_reg(8'h55, cfg[i][2]);
            wr_reg(8'h53, nine[i] ? 8'h50 : 8'h00);
            wr_reg(8'h54, 8'h0C);
            wr_reg(8'h58, 8'h20);
            rd_reg(8'h52, v);
            check(10'(v), 10'(cfg[i][0]));
            rd_reg(8'h50, v);
            wr_reg(8'h51, tb);
            fork
                far.recv(nb, per(cfg[i][0], cfg[i][1], 3), got);
                far.send(rb, nb, per(cfg[i][0], cfg[i][2], 0));
            join
            check(got, nine[i] ? {2'b11, tb} : {2'b01, tb});
            repeat (8) @(posedge clk);
            check(10'(irq), 10'h001);
            rd_reg(8'h50, v);
            check(10'(v[5]), 10'h001);
            rd_reg(8'h51, v);
            check(10'(v), 10'(rb[7:0]));
            if (nine[i]) begin
                rd_reg(8'h53, v);
                check(10'(v[7]), 10'(rb[8]));
            end
            check(10'(irq), 10'h000);
        end
        wr_reg(8'h58, 8'h80);
        check(10'(irq), 10'h001);
        wr_reg(8'h58, 8'h00);
        check(10'(irq), 10'h000);
        conclude();
    end
endmodule : sbr_top_tb
